// ### inc/sdci_pkg.sv
// constants and types for the sdram command and address interface
// Operation
// - activate captures row address; read or write captures column address
// - address bit ten on read or write requests auto precharge
// - precharge closes the selected bank, or all banks when bit ten high
// - mode register load takes the address inputs as op-code
// - with on-the-fly chop enabled, bit twelve high is eight, low four
// - activate, read, write, precharge apply to the bank on bank inputs
// - bank inputs choose which of four mode registers is loaded
// - every control and address input is sampled on rising clock crossing
// - clock enable low enters precharge, self refresh or active power-down
// - clock enable synchronous for entries, asynchronous for self refresh exit
// - power-down keeps only clock, clock enable, reset, termination receivers
// - self refresh keeps only clock enable and reset receivers
// - command decoder works only while chip select registered low
// - command decoded from chip select and three strobe inputs together
// - lower byte beat with lower mask high is discarded
// - termination enable high applies termination, low removes it
// - termination disabled by mode register ignores termination enable
// - reset is active low and acts asynchronously
// - output data strobes are timed to clock crossings
// - upper byte beat with upper mask high is discarded
// - read strobe edge-aligned with data; write strobe centred by controller
package sdci_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 15;
  localparam int BANK_W    = 3;
  localparam int NUM_BANKS = 8;
  localparam int COL_W     = 10;
  localparam int DQ_W      = 16;
  localparam int MR_NUM    = 4;
  localparam int MR_SEL_W  = 2;
  // ---------------------------------------------------------------
  // address field positions
  // ---------------------------------------------------------------
  localparam int AP_BIT    = 10;
  localparam int BC_BIT    = 12;
  localparam int MR0_BL_LO = 0;
  localparam int MR0_BL_HI = 1;
  localparam int MR1_RTT_A = 2;
  localparam int MR1_RTT_B = 6;
  localparam int MR1_RTT_C = 9;
  localparam logic [MR_SEL_W-1:0] MR_TERM_SEL = 2'h1;
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;
  localparam logic [2:0] CODE_MRS  = 3'h0;
  localparam logic [2:0] CODE_REF  = 3'h1;
  localparam logic [2:0] CODE_PRE  = 3'h2;
  localparam logic [2:0] CODE_ACT  = 3'h3;
  localparam logic [2:0] CODE_WR   = 3'h4;
  localparam logic [2:0] CODE_RD   = 3'h5;
  localparam logic [2:0] CODE_ZQ   = 3'h6;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
  } sdci_cmd_type;
  typedef enum logic [1:0] {
    PWR_NORMAL, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF
  } sdci_pwr_type;
endpackage : sdci_pkg

// ### logic/sdci_bank.sv
// one bank: open flag and open row address
`timescale 1ns/10ps
`default_nettype none
module sdci_bank
#(
  parameter int ROW_W = 15
)
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // control
  input  wire logic             i_activate,
  input  wire logic             i_close,
  input  wire logic [ROW_W-1:0] i_row,
  // state
  output logic                  o_open,
  output logic [ROW_W-1:0]      o_row
);
  initial
  begin
    if (ROW_W < 1)
      $error("bank row width must be positive");
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_open <= 1'b0;
      o_row  <= '0;
    end
    else if (i_activate)
    begin
      o_open <= 1'b1;
      o_row  <= i_row;
    end
    else if (i_close)
      o_open <= 1'b0;
  end
endmodule : sdci_bank
`default_nettype wire

// ### logic/sdci_top.sv
// command, address, power and termination logic of the sdram
`timescale 1ns/10ps
`default_nettype none
module sdci_top
#(
  parameter int ADDR_W = sdci_pkg::ADDR_W,
  parameter int DQ_W   = sdci_pkg::DQ_W
)
(
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // command and address pins
  input  wire logic                      i_cke,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_ras_n,
  input  wire logic                      i_cas_n,
  input  wire logic                      i_we_n,
  input  wire logic [sdci_pkg::BANK_W-1:0] i_ba,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic                      i_termination_enable,
  // write beat
  input  wire logic                      i_wbeat_valid,
  input  wire logic [DQ_W-1:0]           i_wdata,
  input  wire logic                      i_lower_byte_mask,
  input  wire logic                      i_upper_byte_mask,
  // read beat
  input  wire logic                      i_rbeat_valid,
  input  wire logic [DQ_W-1:0]           i_rdata,
  // mode register readback
  input  wire logic [sdci_pkg::MR_SEL_W-1:0] i_mr_rd_sel,
  // decoded command
  output sdci_pkg::sdci_cmd_type         o_cmd,
  output logic                           o_cmd_valid,
  output logic [sdci_pkg::BANK_W-1:0]    o_bank,
  output logic [ADDR_W-1:0]              o_row,
  output logic [sdci_pkg::COL_W-1:0]     o_col,
  output logic                           o_auto_precharge_bit,
  output logic                           o_pre_all,
  output logic                           o_burst_len_eight,
  // bank and power state
  output logic [sdci_pkg::NUM_BANKS-1:0] o_bank_open,
  output sdci_pkg::sdci_pwr_type         o_pwr_state,
  output logic                           o_cmd_rx_enable,
  output logic                           o_clk_rx_enable,
  output logic                           o_sr_wake,
  output logic [ADDR_W-1:0]              o_mr_rd_data,
  // termination
  output logic                           o_term_on,
  // write data path
  output logic                           o_wdata_valid,
  output logic [DQ_W-1:0]                o_wdata,
  output logic [1:0]                     o_wr_byte_en,
  // read data path and strobes
  output logic [DQ_W-1:0]                o_rdata,
  output logic                           o_data_oe_n,
  output logic                           o_lower_data_strobe,
  output logic                           o_upper_data_strobe
);
  import sdci_pkg::*;

  initial
  begin
    if (ADDR_W <= BC_BIT || DQ_W != 16)
      $error("address must reach bit twelve; data must be 16 bits");
  end

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  logic                  r_cke;
  logic                  r_cke_d;
  logic                  r_cs_n;
  logic [2:0]            r_code;
  logic [BANK_W-1:0]     r_ba;
  logic [ADDR_W-1:0]     r_addr;
  logic                  r_odt;
  sdci_pwr_type          state;
  sdci_pwr_type          next_state;

  assign o_cmd_rx_enable = (state == PWR_NORMAL);
  // clock receiver off in self refresh
  assign o_clk_rx_enable = (state != PWR_SELF_REF);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r_cs_n <= 1'b1;
      r_code <= 3'h7;
      r_ba   <= '0;
      r_addr <= '0;
    end
    else if (o_cmd_rx_enable)
    begin
      r_cs_n <= i_cs_n;
      r_code <= {i_ras_n, i_cas_n, i_we_n};
      r_ba   <= i_ba;
      r_addr <= i_addr;
    end
    else
      r_cs_n <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r_cke   <= 1'b0;
      r_cke_d <= 1'b0;
    end
    else
    begin
      r_cke   <= i_cke;
      r_cke_d <= r_cke;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      r_odt <= 1'b0;
    else if (o_clk_rx_enable)
      r_odt <= i_termination_enable;
    else
      r_odt <= 1'b0;
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  sdci_cmd_type dec;
  logic         dec_live;

  always_comb
  begin
    case (r_code)
      CODE_MRS: dec = CMD_MRS;
      CODE_REF: dec = CMD_REF;
      CODE_PRE: dec = CMD_PRE;
      CODE_ACT: dec = CMD_ACT;
      CODE_WR:  dec = CMD_WR;
      CODE_RD:  dec = CMD_RD;
      CODE_ZQ:  dec = CMD_ZQ;
      default:  dec = CMD_NOP;
    endcase
  end

  assign dec_live = !r_cs_n && r_cke && (state == PWR_NORMAL)
                    && (dec != CMD_NOP);

  logic is_act;
  logic is_pre;
  logic is_col;
  logic is_mrs;
  assign is_act = dec_live && (dec == CMD_ACT);
  assign is_pre = dec_live && (dec == CMD_PRE);
  assign is_col = dec_live && (dec == CMD_WR || dec == CMD_RD);
  assign is_mrs = dec_live && (dec == CMD_MRS);

  // ---------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] mode_reg [MR_NUM];
  logic              otf_on;
  logic              fixed8;
  logic              term_allowed;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < MR_NUM; i++)
        mode_reg[i] <= MR_RESET;
    end
    else if (is_mrs)
      mode_reg[r_ba[MR_SEL_W-1:0]] <= r_addr;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_mr_rd_data <= MR_RESET;
    else
      o_mr_rd_data <= mode_reg[i_mr_rd_sel];
  end

  assign otf_on = (mode_reg[0][MR0_BL_HI:MR0_BL_LO] == BL_OTF);
  assign fixed8 = (mode_reg[0][MR0_BL_HI:MR0_BL_LO] == BL_FIXED8);
  // all-zero nominal value means termination switched off
  assign term_allowed = mode_reg[MR_TERM_SEL][MR1_RTT_A]
                     || mode_reg[MR_TERM_SEL][MR1_RTT_B]
                     || mode_reg[MR_TERM_SEL][MR1_RTT_C];

  // ---------------------------------------------------------------
  // banks
  // ---------------------------------------------------------------
  logic [NUM_BANKS-1:0] bank_close;
  logic                 any_open;

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++)
    begin : gen_bank
      assign bank_close[g] = (is_pre && (r_addr[AP_BIT]
                               || r_ba == BANK_W'(g)))
                          || (is_col && r_addr[AP_BIT]
                               && r_ba == BANK_W'(g));
      sdci_bank #(.ROW_W(ADDR_W)) u_bank (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_activate (is_act && r_ba == BANK_W'(g)),
        .i_close    (bank_close[g]),
        .i_row      (r_addr),
        .o_open     (o_bank_open[g]),
        .o_row      ()
      );
    end
  endgenerate

  assign any_open = |o_bank_open;

  // ---------------------------------------------------------------
  // decoded command outputs
  // ---------------------------------------------------------------
  // capture row and column
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cmd                <= CMD_NOP;
      o_cmd_valid          <= 1'b0;
      o_bank               <= '0;
      o_row                <= '0;
      o_col                <= '0;
      o_auto_precharge_bit <= 1'b0;
      o_pre_all            <= 1'b0;
      o_burst_len_eight    <= 1'b1;
    end
    else
    begin
      o_cmd_valid <= dec_live;
      o_cmd       <= dec_live ? dec : CMD_NOP;
      if (dec_live)
        o_bank <= r_ba;
      if (is_act)
        o_row <= r_addr;
      if (is_col)
      begin
        o_col                <= r_addr[COL_W-1:0];
        o_auto_precharge_bit <= r_addr[AP_BIT];
        o_burst_len_eight    <= otf_on ? r_addr[BC_BIT] : fixed8;
      end
      if (dec_live)
        o_pre_all <= is_pre && r_addr[AP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  logic cke_fall;
  logic sr_req;
  assign cke_fall = r_cke_d && !r_cke && (state == PWR_NORMAL);
  assign sr_req   = !r_cs_n && (dec == CMD_REF);
  // self refresh exit needs no clock
  assign o_sr_wake = (state == PWR_SELF_REF) && i_cke;
  assign o_pwr_state = state;

  // entry picks mode by bank state
  always_comb
  begin
    next_state = state;
    case (state)
      PWR_NORMAL:
      begin
        if (cke_fall && sr_req && !any_open)
          next_state = PWR_SELF_REF;
        else if (cke_fall)
          next_state = any_open ? PWR_PD_ACT : PWR_PD_PRE;
      end
      PWR_PD_PRE, PWR_PD_ACT:
      begin
        if (r_cke)
          next_state = PWR_NORMAL;
      end
      PWR_SELF_REF:
      begin
        if (i_cke)
          next_state = PWR_NORMAL;
      end
      default: next_state = PWR_NORMAL;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state <= PWR_NORMAL;
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------
  // termination
  // ---------------------------------------------------------------
  // registered enable drives termination
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_term_on <= 1'b0;
    else
      o_term_on <= r_odt && term_allowed
                   && (state != PWR_SELF_REF);
  end

  // ---------------------------------------------------------------
  // write and read beats
  // ---------------------------------------------------------------
  // lower mask drops byte
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_wdata_valid <= 1'b0;
      o_wdata       <= '0;
      o_wr_byte_en  <= 2'h0;
    end
    else
    begin
      o_wdata_valid <= i_wbeat_valid;
      o_wdata       <= i_wdata;
      o_wr_byte_en  <= i_wbeat_valid ?
                       {!i_upper_byte_mask, !i_lower_byte_mask} : 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rdata             <= '0;
      o_data_oe_n         <= 1'b1;
      o_lower_data_strobe <= 1'b0;
      o_upper_data_strobe <= 1'b0;
    end
    else
    begin
      o_data_oe_n <= !i_rbeat_valid;
      if (i_rbeat_valid)
      begin
        o_rdata             <= i_rdata;
        o_lower_data_strobe <= !o_lower_data_strobe;
        o_upper_data_strobe <= !o_upper_data_strobe;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_cke_drop_idle;
    cke_fall && !sr_req && !any_open;
  endsequence
  sequence s_cke_drop_open;
    cke_fall && any_open;
  endsequence

  cs_mask_a: assert property (r_cs_n |=> !o_cmd_valid)
    else $error("command decoded with chip select high");
  act_row_a: assert property (is_act |=> o_row == $past(r_addr)
    && o_bank_open[$past(r_ba)])
    else $error("activate row not captured");
  ap_bit_a: assert property (is_col |=>
    o_auto_precharge_bit == $past(r_addr[AP_BIT]))
    else $error("auto precharge bit wrong");
  pre_all_a: assert property (is_pre && r_addr[AP_BIT] |=>
    o_bank_open == '0 && o_pre_all)
    else $error("precharge all left a bank open");
  chop_sel_a: assert property (is_col && otf_on |=>
    o_burst_len_eight == $past(r_addr[BC_BIT]))
    else $error("burst chop selection wrong");
  mrs_load_a: assert property (is_mrs |=>
    mode_reg[$past(r_ba[MR_SEL_W-1:0])] == $past(r_addr))
    else $error("mode register not loaded");
  pd_entry_a: assert property (s_cke_drop_idle |=>
    state == PWR_PD_PRE)
    else $error("precharge power-down not entered");
  pd_act_a: assert property (s_cke_drop_open |=>
    state == PWR_PD_ACT ##1 !o_cmd_rx_enable)
    else $error("active power-down not entered");
  sr_term_a: assert property (state == PWR_SELF_REF |=>
    !o_term_on || state != PWR_SELF_REF)
    else $error("termination on in self refresh");
  term_veto_a: assert property (!term_allowed |=> !o_term_on)
    else $error("termination on while disabled");
  byte_mask_a: assert property (i_wbeat_valid |=>
    o_wr_byte_en == ~{$past(i_upper_byte_mask),
                      $past(i_lower_byte_mask)})
    else $error("byte mask not applied");
  strobe_a: assert property (i_rbeat_valid |=>
    o_lower_data_strobe != $past(o_lower_data_strobe)
    && !o_data_oe_n)
    else $error("read strobe not toggled with data");
endmodule : sdci_top
`default_nettype wire

// ### tb/sdci_ctrl_model.sv
// controller model driving command pins, levels and data beats
`timescale 1ns/10ps
`default_nettype none
module sdci_ctrl_model
(
  // clock
  input  wire logic                   i_clk,
  // command pins and levels
  output logic                        o_cke,
  output logic                        o_cs_n,
  output logic                        o_ras_n,
  output logic                        o_cas_n,
  output logic                        o_we_n,
  output logic [sdci_pkg::BANK_W-1:0] o_ba,
  output logic [sdci_pkg::ADDR_W-1:0] o_addr,
  output logic                        o_term,
  // data beats
  output logic                        o_wvalid,
  output logic                        o_rvalid,
  output logic [sdci_pkg::DQ_W-1:0]   o_data,
  output logic                        o_lmask,
  output logic                        o_umask
);
  import sdci_pkg::*;
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial
  begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_ba = 3'h0;
    o_addr = 15'h0000;
    o_term = 1'b0;
    o_wvalid = 1'b0;
    o_rvalid = 1'b0;
    o_data = 16'h0000;
    o_lmask = 1'b0;
    o_umask = 1'b0;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  // held over sampling edge
  task automatic cmd(input logic cs_n, input logic [2:0] code,
    input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] addr,
    input logic cke);
    @(posedge i_clk);
    #10;
    o_cke = cke;
    o_cs_n = cs_n;
    {o_ras_n, o_cas_n, o_we_n} = code;
    o_ba = ba;
    o_addr = addr;
    @(posedge i_clk);
    #10;
    o_cs_n = 1'b1;
    // released lines toggle so stale values never look valid
    {o_ras_n, o_cas_n, o_we_n} = ~code;
    o_ba = ~ba;
    o_addr = ~addr;
  endtask : cmd
  task automatic levels(input logic cke, input logic term);
    o_cke = cke;
    o_term = term;
  endtask : levels
  task automatic beat(input logic wr, input logic [DQ_W-1:0] d,
    input logic lm, input logic um);
    @(posedge i_clk);
    #10;
    o_wvalid = wr;
    o_rvalid = ~wr;
    o_data = d;
    o_lmask = lm;
    o_umask = um;
    @(posedge i_clk);
    #10;
    o_wvalid = 1'b0;
    o_rvalid = 1'b0;
    o_data = ~d;
    o_lmask = ~lm;
    o_umask = ~um;
  endtask : beat
endmodule : sdci_ctrl_model
`default_nettype wire

// ### tb/sdci_top_bench.sv
// self-checking bench for the sdram command and address logic
`timescale 1ns/10ps
`default_nettype none
module sdci_top_bench;
  import sdci_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic         clk, reset_n, cke, cs_n, ras_n, cas_n, we_n, term;
  logic         wv, rv, lm, um, cv, ap, pa, b8, crx, ckrx, srw, ton;
  logic         wv_o, oe_n, ls, us;
  logic [1:0]   mr_sel, ben, stb;
  logic [2:0]   ba, bank;
  logic [14:0]  addr, row, mr_data;
  logic [15:0]  dq, wd_o, rd_o;
  logic [9:0]   col;
  logic [7:0]   bopen;
  sdci_cmd_type cmd;
  sdci_pwr_type pwr;
  int           errors, checked;
  sdci_ctrl_model i_sdci_ctrl_model
  (
    .i_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr),
    .o_term(term), .o_wvalid(wv), .o_rvalid(rv), .o_data(dq),
    .o_lmask(lm), .o_umask(um)
  );
  sdci_top i_sdci_top
  (
    .i_clk(clk), .i_reset_n(reset_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba),
    .i_addr(addr), .i_termination_enable(term), .i_wbeat_valid(wv),
    .i_wdata(dq), .i_lower_byte_mask(lm), .i_upper_byte_mask(um),
    .i_rbeat_valid(rv), .i_rdata(dq), .i_mr_rd_sel(mr_sel),
    .o_cmd(cmd), .o_cmd_valid(cv), .o_bank(bank), .o_row(row),
    .o_col(col), .o_auto_precharge_bit(ap), .o_pre_all(pa),
    .o_burst_len_eight(b8), .o_bank_open(bopen), .o_pwr_state(pwr),
    .o_cmd_rx_enable(crx), .o_clk_rx_enable(ckrx), .o_sr_wake(srw),
    .o_mr_rd_data(mr_data), .o_term_on(ton), .o_wdata_valid(wv_o),
    .o_wdata(wd_o), .o_wr_byte_en(ben), .o_rdata(rd_o),
    .o_data_oe_n(oe_n), .o_lower_data_strobe(ls),
    .o_upper_data_strobe(us)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  // outputs of a command show one edge after it is taken
  task automatic op(input logic [2:0] c, input logic [2:0] b,
    input logic [14:0] a);
    i_sdci_ctrl_model.cmd(1'b0, c, b, a, 1'b1);
    step(1);
  endtask : op
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial
  begin
    reset_n = 1'b0;
    mr_sel = 2'h0;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    #10;
    chk("rst cmd", cmd, CMD_NOP);
    chk("rst bl8", b8, 1'b1);
    chk("rst oe_n", oe_n, 1'b1);
    reset_n = 1'b1;
    op(CODE_ACT, 3'h5, 15'h5A5A);
    chk("cmd act", cmd, CMD_ACT);
    chk("valid", cv, 1'b1);
    chk("bank", bank, 3'h5);
    chk("row", row, 15'h5A5A);
    chk("open", bopen, 8'h20);
    op(CODE_WR, 3'h5, 15'h07FF);
    chk("cmd wr", cmd, CMD_WR);
    chk("col", col, 10'h3FF);
    chk("auto pre", ap, 1'b1);
    op(CODE_REF, 3'h0, 15'h0000);
    chk("cmd ref", cmd, CMD_REF);
    op(CODE_ZQ, 3'h0, 15'h0000);
    chk("cmd zq", cmd, CMD_ZQ);
    op(3'h7, 3'h0, 15'h0000);
    chk("nop code", cv, 1'b0);
    i_sdci_ctrl_model.cmd(1'b1, CODE_ACT, 3'h3, 15'h0033, 1'b1);
    step(1);
    chk("cs high", cv, 1'b0);
    chk("cs high open", bopen[3], 1'b0);
    $display("test decode done");
    op(CODE_MRS, 3'h0, {13'h0000, BL_OTF});
    chk("cmd mrs", cmd, CMD_MRS);
    op(CODE_MRS, 3'h3, 15'h1234);
    step(1);
    chk("mode 0", mr_data, 15'h0001);
    mr_sel = 2'h3;
    step(1);
    chk("mode 3", mr_data, 15'h1234);
    op(CODE_RD, 3'h2, 15'h0000);
    chk("cmd rd", cmd, CMD_RD);
    chk("chop four", b8, 1'b0);
    op(CODE_RD, 3'h2, 15'h1000);
    chk("eight", b8, 1'b1);
    // chop disabled: bit twelve must no longer pick the length
    op(CODE_MRS, 3'h0, 15'h0002);
    op(CODE_WR, 3'h2, 15'h1000);
    chk("fixed four", b8, 1'b0);
    op(CODE_MRS, 3'h1, 15'h0004);
    i_sdci_ctrl_model.levels(1'b1, 1'b1);
    step(2);
    chk("term on", ton, 1'b1);
    i_sdci_ctrl_model.levels(1'b1, 1'b0);
    step(2);
    chk("term off", ton, 1'b0);
    op(CODE_MRS, 3'h1, 15'h0000);
    i_sdci_ctrl_model.levels(1'b1, 1'b1);
    step(2);
    chk("term ignored", ton, 1'b0);
    i_sdci_ctrl_model.levels(1'b1, 1'b0);
    $display("test mode done");
    op(CODE_ACT, 3'h1, 15'h0011);
    op(CODE_ACT, 3'h2, 15'h0022);
    op(CODE_PRE, 3'h1, 15'h0000);
    chk("pre one", bopen[2:1], 2'h2);
    chk("pre one flag", pa, 1'b0);
    op(CODE_PRE, 3'h0, 15'h0400);
    chk("pre all", bopen, 8'h00);
    chk("pre all flag", pa, 1'b1);
    $display("test precharge done");
    i_sdci_ctrl_model.beat(1'b1, 16'hABCD, 1'b1, 1'b0);
    chk("wvalid", wv_o, 1'b1);
    chk("wdata", wd_o, 16'hABCD);
    chk("lower drop", ben, 2'h2);
    i_sdci_ctrl_model.beat(1'b1, 16'h1234, 1'b0, 1'b1);
    chk("upper drop", ben, 2'h1);
    stb = {ls, us};
    i_sdci_ctrl_model.beat(1'b0, 16'h5AA5, 1'b0, 1'b0);
    chk("rdata", rd_o, 16'h5AA5);
    chk("oe_n", oe_n, 1'b0);
    chk("strobes", {ls, us}, 2'(~stb));
    i_sdci_ctrl_model.beat(1'b0, 16'hC33C, 1'b0, 1'b0);
    chk("strobes again", {ls, us}, stb);
    $display("test beats done");
    i_sdci_ctrl_model.levels(1'b0, 1'b0);
    step(2);
    chk("pd pre", pwr, PWR_PD_PRE);
    chk("cmd rx off", crx, 1'b0);
    chk("clk rx on", ckrx, 1'b1);
    i_sdci_ctrl_model.cmd(1'b0, CODE_ACT, 3'h4, 15'h0044, 1'b0);
    step(1);
    chk("pd ignore", bopen, 8'h00);
    i_sdci_ctrl_model.levels(1'b1, 1'b0);
    step(2);
    chk("pd exit", pwr, PWR_NORMAL);
    op(CODE_ACT, 3'h4, 15'h0044);
    i_sdci_ctrl_model.levels(1'b0, 1'b0);
    step(2);
    chk("pd act", pwr, PWR_PD_ACT);
    i_sdci_ctrl_model.levels(1'b1, 1'b0);
    step(2);
    op(CODE_PRE, 3'h0, 15'h0400);
    i_sdci_ctrl_model.cmd(1'b0, CODE_REF, 3'h0, 15'h0000, 1'b0);
    step(1);
    chk("self ref", pwr, PWR_SELF_REF);
    chk("clk rx off", ckrx, 1'b0);
    #20;
    i_sdci_ctrl_model.levels(1'b1, 1'b0);
    #1;
    chk("sr wake", srw, 1'b1);
    step(1);
    chk("sr exit", pwr, PWR_NORMAL);
    $display("test power done");
    op(CODE_ACT, 3'h6, 15'h0066);
    chk("open six", bopen[6], 1'b1);
    // reset held across two edges, released off the edge like all stimulus
    reset_n = 1'b0;
    #5;
    chk("async rst", bopen, 8'h00);
    step(2);
    reset_n = 1'b1;
    op(CODE_ACT, 3'h7, 15'h0077);
    chk("after rst", bopen, 8'h80);
    $display("test reset done");
    end_of_test();
  end
endmodule : sdci_top_bench
`default_nettype wire
